// File: rtl/pchr_defs.svh
// Function
// R1 - capability id byte always reads 10h
// R2 - next pointer byte always reads 00h
// R3 - capability version nibble reads 2h
// R4 - port type reads 0101b upstream, 0110b downstream
// R5 - slot bit resets 0 upstream, 1 downstream; overridable by management
// R6 - interrupt message number reads zero
// R7 - payload codes 000b=128, 001b=256, 010b=512; others reserved
// R8 - payload supported resets 001b, overridable by management, max 512
// R9 - phantom functions field reads 00b
// R10 - extended tag bit reads zero
// R11 - L0s acceptable latency resets 000b
// R12 - L1 acceptable latency resets 000b
// R13 - role-based error bit resets one, overridable by management
// R14 - upstream slot power value loaded from message, else zero
// R15 - upstream slot power scale loaded from message, else zero
// R16 - writes to header and capability words change nothing; reserved bits read zero
// R17 - control payload writes above supported size clamp to supported
`ifndef PCHR_DEFS_SVH
`define PCHR_DEFS_SVH
`define PCHR_OFS_CAPHDR 12'h0c0
`define PCHR_OFS_DEVCAP 12'h0c4
`define PCHR_OFS_DEVCTL 12'h0c8
`define PCHR_OFS_OVR 12'h100
`define PCHR_CAP_ID 8'h10
`define PCHR_NEXT_PTR 8'h00
`define PCHR_CAP_VER 4'h2
`define PCHR_TYPE_UP 4'h5
`define PCHR_TYPE_DN 4'h6
`define PCHR_MSG_NUM 5'h00
`define PCHR_MPS_RST 3'h1
`define PCHR_MPS_MAX 3'h2
`define PCHR_CTL_MPS_RST 3'h0
`define PCHR_RBER_RST 1'h1
`define PCHR_SLOT_UP_RST 1'h0
`define PCHR_SLOT_DN_RST 1'h1
`define PCHR_LAT_RST 3'h0
`define PCHR_SPL_VAL_RST 8'h00
`define PCHR_SPL_SCL_RST 2'h0
`define PCHR_POS_ID 0
`define PCHR_POS_NEXT 8
`define PCHR_POS_VER 16
`define PCHR_POS_TYPE 20
`define PCHR_POS_SLOT 24
`define PCHR_POS_MSG 25
`define PCHR_POS_PHAN 3
`define PCHR_POS_ETAG 5
`define PCHR_POS_L0S 6
`define PCHR_POS_L1 9
`define PCHR_POS_RBER 15
`define PCHR_POS_SPLV 18
`define PCHR_POS_SPLS 26
`define PCHR_POS_CMPS 5
`endif

// File: rtl/pchr_pkg.sv
`include "pchr_defs.svh"
package pchr_pkg;
	typedef logic [2:0] pchr_mps_t;
	typedef logic [11:0] pchr_addr_t;
	typedef enum logic [1:0] {
		PCHR_IDLE = 2'h0,
		PCHR_ACCESS = 2'h1
	} pchr_state_e;
	// payload code is legal when one of the three defined encodings
	function automatic logic pchr_mps_legal(input pchr_mps_t code);
		pchr_mps_legal = (code <= `PCHR_MPS_MAX);
	endfunction
endpackage

// File: rtl/pchr_pwr_capture.sv
`timescale 1ns/100ps
`include "pchr_defs.svh"
module pchr_pwr_capture (
	input wire logic core_clk, // core clock
	input wire logic rst_n, // async reset, low active
	input wire logic clkEn, // freezes state when low
	input wire logic isUpstream, // port role
	input wire logic splValid, // set slot power message received
	input wire logic [7:0] splValue, // message value byte
	input wire logic [1:0] splScale, // message scale
	output logic [7:0] capValue, // captured value
	output logic [1:0] capScale // captured scale
);
	logic [7:0] capValue_r;
	logic [1:0] capScale_r;
	// capture only on upstream port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			capValue_r <= `PCHR_SPL_VAL_RST; // R14
			capScale_r <= `PCHR_SPL_SCL_RST; // R15
		end else if (clkEn && splValid && isUpstream) begin
			capValue_r <= splValue; // R14
			capScale_r <= splScale; // R15
		end
	end
	assign capValue = capValue_r;
	assign capScale = capScale_r;
endmodule

// File: rtl/pchr_cap_regs.sv
`timescale 1ns/100ps
`include "pchr_defs.svh"
module pchr_cap_regs (
	input wire logic core_clk, // core clock
	input wire logic rst_n, // async reset, low active
	input wire logic clkEn, // freezes state when low
	input wire logic isUpstream, // port role, from same-clock logic
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic ovrValid, // management override load strobe
	input wire logic ovrSlot, // override slot implemented
	input wire logic [2:0] ovrMps, // override payload supported
	input wire logic ovrRber, // override role-based error bit
	input wire logic splValid, // slot power message strobe
	input wire logic [7:0] splValue, // message value byte
	input wire logic [1:0] splScale, // message scale
	output logic [2:0] ctlMps // effective control payload size
);
	logic slot_r;
	logic [2:0] mps_r;
	logic rber_r;
	logic [2:0] ctlMps_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic roleSeen_r;
	logic [7:0] capValue;
	logic [1:0] capScale;
	logic [31:0] hdrWord;
	logic [31:0] capWord;
	logic [31:0] ovrWord;
	logic [31:0] rdMux;
	logic rdHit;
	logic access;
	pchr_pkg::pchr_mps_t wrMps;

	// clamp a written payload size to the advertised limit
	function automatic logic [2:0] clampMps(input logic [2:0] req,
		input logic [2:0] lim);
		clampMps = (req > lim) ? lim : req;
	endfunction

	pchr_pwr_capture u_pwr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.isUpstream(isUpstream),
		.splValid(splValid),
		.splValue(splValue),
		.splScale(splScale),
		.capValue(capValue),
		.capScale(capScale)
	);

	assign access = psel && penable && clkEn;
	assign pready = 1'b1;

	// slot default follows role once reset is released
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_r <= `PCHR_SLOT_UP_RST;
			roleSeen_r <= 1'b0;
		end else if (clkEn) begin
			if (ovrValid) begin
				slot_r <= ovrSlot; // R5
				roleSeen_r <= 1'b1;
			end else if (!roleSeen_r) begin
				slot_r <= isUpstream ? `PCHR_SLOT_UP_RST :
					`PCHR_SLOT_DN_RST; // R5
				roleSeen_r <= 1'b1;
			end
		end
	end

	// management-loadable defaults, illegal payload codes ignored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mps_r <= `PCHR_MPS_RST; // R8
			rber_r <= `PCHR_RBER_RST; // R13
		end else if (clkEn && ovrValid) begin
			if (pchr_pkg::pchr_mps_legal(ovrMps)) begin
				mps_r <= ovrMps; // R7
			end
			rber_r <= ovrRber; // R13
		end
	end

	// control payload size with clamping on write
	assign wrMps = pwdata[`PCHR_POS_CMPS +: 3];
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctlMps_r <= `PCHR_CTL_MPS_RST;
		end else if (clkEn) begin
			if (access && pwrite && paddr == `PCHR_OFS_DEVCTL) begin
				ctlMps_r <= clampMps(wrMps, mps_r); // R17
			end else if (ctlMps_r > mps_r) begin
				ctlMps_r <= mps_r; // R17
			end
		end
	end
	assign ctlMps = ctlMps_r;

	// capability header word
	always_comb begin
		hdrWord = 32'h0; // R16
		hdrWord[`PCHR_POS_ID +: 8] = `PCHR_CAP_ID; // R1
		hdrWord[`PCHR_POS_NEXT +: 8] = `PCHR_NEXT_PTR; // R2
		hdrWord[`PCHR_POS_VER +: 4] = `PCHR_CAP_VER; // R3
		hdrWord[`PCHR_POS_TYPE +: 4] = isUpstream ? `PCHR_TYPE_UP :
			`PCHR_TYPE_DN; // R4
		hdrWord[`PCHR_POS_SLOT] = slot_r; // R5
		hdrWord[`PCHR_POS_MSG +: 5] = `PCHR_MSG_NUM; // R6
	end

	// device capabilities word
	always_comb begin
		capWord = 32'h0; // R16
		capWord[2:0] = mps_r; // R8
		capWord[`PCHR_POS_PHAN +: 2] = 2'h0; // R9
		capWord[`PCHR_POS_ETAG] = 1'b0; // R10
		capWord[`PCHR_POS_L0S +: 3] = `PCHR_LAT_RST; // R11
		capWord[`PCHR_POS_L1 +: 3] = `PCHR_LAT_RST; // R12
		capWord[`PCHR_POS_RBER] = rber_r; // R13
		capWord[`PCHR_POS_SPLV +: 8] = capValue; // R14
		capWord[`PCHR_POS_SPLS +: 2] = capScale; // R15
	end

	// read decode; control word shows payload field only
	always_comb begin
		ovrWord = 32'h0;
		ovrWord[`PCHR_POS_CMPS +: 3] = ctlMps_r;
		rdHit = 1'b1;
		unique case (paddr)
			`PCHR_OFS_CAPHDR: rdMux = hdrWord;
			`PCHR_OFS_DEVCAP: rdMux = capWord;
			`PCHR_OFS_DEVCTL: rdMux = ovrWord;
			default: begin
				rdMux = 32'h0;
				rdHit = 1'b0;
			end
		endcase
	end

	// registered read data and error; writes to cap words dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (clkEn && psel && !penable) begin
			prdata_r <= pwrite ? 32'h0 : rdMux; // R16
			pslverr_r <= !rdHit;
		end
	end
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
endmodule

// File: tb/pchr_chk.sv
`timescale 1ns/100ps
module pchr_chk (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset
	input wire logic clkEn, // enable
	input wire logic isUpstream, // role
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic ovrValid, // override strobe
	input wire logic [2:0] ovrMps, // override size
	input wire logic [2:0] ctlMps // control size
);
	logic [2:0] supR;
	// supported size as last legally loaded
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			supR <= 3'h1;
		else if (ovrValid && clkEn && ovrMps <= 3'h2)
			supR <= ovrMps;
	end
	// read cycles of header and capability words
	wire rd = psel & penable & ~pwrite & clkEn;
	wire rd0 = rd & (paddr == 12'h0c0);
	wire rd4 = rd & (paddr == 12'h0c4);
	wire bad = paddr != 12'h0c0 && paddr != 12'h0c4 && paddr != 12'h0c8;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	hdr_fixed_a: assert property (rd0 |-> prdata[19:0] == 20'h20010
		&& prdata[31:25] == 7'h0) else $error("header constant wrong");
	port_type_a: assert property (rd0 |-> prdata[23:20] ==
		(isUpstream ? 4'h5 : 4'h6)) else $error("port type wrong");
	cap_fixed_a: assert property (rd4 |-> prdata[14:3] == 12'h0
		&& prdata[17:16] == 2'h0 && prdata[31:28] == 4'h0)
		else $error("device caps constant wrong");
	mps_value_a: assert property (rd4 |-> prdata[2:0] == supR)
		else $error("supported size wrong");
	spl_down_a: assert property (rd4 && !isUpstream |->
		prdata[27:18] == 10'h0) else $error("slot power on downstream");
	ready_now_a: assert property (psel && penable &&
		$past(psel && !penable && clkEn) |-> pready &&
		((!pwrite && !bad) || prdata == 32'h0))
		else $error("no ready or nonzero refused data");
	unmapped_err_a: assert property (psel && !penable && clkEn |=>
		pslverr == $past(bad)) else $error("error flag wrong");
	ctl_clamp_a: assert property ($stable(supR) |-> ctlMps <= supR)
		else $error("control size not clamped");
endmodule
bind pchr_cap_regs pchr_chk chk (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.clkEn(clkEn),
	.isUpstream(isUpstream),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.ovrValid(ovrValid),
	.ovrMps(ovrMps),
	.ctlMps(ctlMps)
);

// File: tb/pchr_msg_src.sv
`timescale 1ns/100ps
module pchr_msg_src (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset
	input wire logic go, // send one message
	input wire logic [9:0] msg, // scale and value
	output logic splValid, // message strobe
	output logic [7:0] splValue, // value byte
	output logic [1:0] splScale // scale
);
	// one-cycle message strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			splValid <= 1'b0;
		end else begin
			splValid <= go;
		end
	end
	// between messages the lines invert every cycle
	always_ff @(posedge core_clk) begin
		{splScale, splValue} <= go ? msg : ~{splScale, splValue};
	end
endmodule

// File: tb/tb_pcie_capability_header_regs.sv
`timescale 1ns/100ps
module tb_pcie_capability_header_regs;
	logic core_clk, rst_n, clkEn, isUpstream, psel, penable, pwrite, go;
	logic ovrValid, ovrSlot, ovrRber, pready, pslverr, splValid, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] ovrMps, ctlMps;
	logic [9:0] msg;
	logic [7:0] splValue;
	logic [1:0] splScale;
	int bad_count, checked;
	typedef struct {logic [11:0] a; logic [31:0] d; logic e;} pchr_row_s;
	pchr_row_s rows [5] = '{'{12'h0c0, 32'h01620010, 1'b0},
		'{12'h0c4, 32'h00008001, 1'b0}, '{12'h0c8, 32'h0, 1'b0},
		'{12'h0cc, 32'h0, 1'b1}, '{12'h100, 32'h0, 1'b1}};
	pchr_cap_regs dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.isUpstream(isUpstream),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ovrValid(ovrValid),
		.ovrSlot(ovrSlot),
		.ovrMps(ovrMps),
		.ovrRber(ovrRber),
		.splValid(splValid),
		.splValue(splValue),
		.splScale(splScale),
		.ctlMps(ctlMps)
	);
	pchr_msg_src src (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.go(go),
		.msg(msg),
		.splValid(splValid),
		.splValue(splValue),
		.splScale(splScale)
	);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task rst(input logic up);
		{rst_n, isUpstream} <= {1'b0, up};
		repeat (6) @(posedge core_clk);
		rst_n <= 1;
		repeat (2) @(posedge core_clk);
	endtask
	task ovr(input logic s, input logic [2:0] m, input logic r);
		@(posedge core_clk);
		{ovrValid, ovrSlot, ovrMps, ovrRber} <= {1'b1, s, m, r};
		@(posedge core_clk);
		ovrValid <= 0;
	endtask
	task send(input logic [9:0] m);
		@(posedge core_clk);
		{go, msg} <= {1'b1, m};
		@(posedge core_clk);
		go <= 0;
	endtask
	initial begin
		{rst_n, isUpstream, psel, penable, pwrite, paddr, pwdata} = '0;
		{ovrValid, ovrSlot, ovrMps, ovrRber, go, msg} = '0;
		clkEn = 1;
		rst(0);
		// reset values and address decode
		foreach (rows[i]) begin
			apb(0, rows[i].a, 0);
			chk("rdata", rows[i].d, rd);
			chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
		end
		// writes and a downstream message leave the device capabilities word alone
		send(10'h2a5);
		apb(1, 12'h0c0, 32'hffffffff);
		apb(1, 12'h0c4, 32'hffffffff);
		apb(0, 12'h0c4, 0);
		chk("devcap ro", 32'h00008001, rd);
		// override, then oversized control write
		ovr(0, 3'h2, 0);
		apb(1, 12'h0c8, 32'h00000020);
		apb(0, 12'h0c8, 0);
		chk("ctl fit", 32'h20, rd);
		apb(1, 12'h0c8, 32'h000000e0);
		apb(0, 12'h0c8, 0);
		chk("ctl", 32'h40, rd);
		apb(0, 12'h0c4, 0);
		chk("devcap ovr", 32'h2, rd);
		apb(0, 12'h0c0, 0);
		chk("hdr ovr", 32'h00620010, rd);
		// frozen enable ignores override
		@(posedge core_clk);
		clkEn <= 0;
		ovr(1, 3'h0, 1);
		@(posedge core_clk);
		clkEn <= 1;
		apb(0, 12'h0c4, 0);
		chk("frozen", 32'h2, rd);
		// shrinking support clamps control
		ovr(1, 3'h0, 1);
		apb(0, 12'h0c8, 0);
		chk("ctl shrink", 32'h0, rd);
		apb(0, 12'h0c4, 0);
		chk("devcap 2", 32'h00008000, rd);
		// reserved payload code from management is ignored
		ovr(1, 3'h7, 1);
		apb(0, 12'h0c4, 0);
		chk("devcap rsvd", 32'h00008000, rd);
		// upstream instance captures slot power
		rst(1);
		apb(0, 12'h0c0, 0);
		chk("hdr up", 32'h00520010, rd);
		send(10'h2a5);
		apb(0, 12'h0c4, 0);
		chk("spl", 32'h0a948001, rd);
		report_and_stop;
	end
	// hang guard
	initial begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		report_and_stop;
	end
endmodule
